// >>> core/fpc_consts.svh
// Constants for the fan drive setup and freewheel test block.
// Assumes a single 40 MHz system clock; included by the package and design modules.
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH
// Register offsets
`define FPC_OFS_RAMP34      8'h1B
`define FPC_OFS_FW_START    8'h1C
`define FPC_OFS_FITTED      8'h1D
`define FPC_OFS_FW_PERMIT   8'h1E
`define FPC_OFS_CH1_SETUP   8'h21
`define FPC_OFS_CH2_SETUP   8'h22
`define FPC_OFS_CH3_SETUP   8'h23
`define FPC_OFS_CH4_SETUP   8'h24
// Reset values
`define FPC_RST_ZERO        8'h00
`define FPC_RST_CH1_SETUP   8'h11
`define FPC_RST_CH2_SETUP   8'h31
`define FPC_RST_CH3_SETUP   8'h51
`define FPC_RST_CH4_SETUP   8'h71
// Field positions
`define FPC_BIT_EN3         0
`define FPC_BIT_EN4         1
`define FPC_RATE3_LSB       2
`define FPC_RATE4_LSB       5
`define FPC_TMO_LSB         0
`define FPC_BIT_SLOW        3
`define FPC_BIT_POL         4
`define FPC_SRC_LSB         5
`define FPC_SRC_OFF         3'h4
// Ramp increments per time slot, by code
`define FPC_STEP_0          8'h01
`define FPC_STEP_1          8'h02
`define FPC_STEP_2          8'h03
`define FPC_STEP_3          8'h05
`define FPC_STEP_4          8'h08
`define FPC_STEP_5          8'h0C
`define FPC_STEP_6          8'h18
`define FPC_STEP_7          8'h30
`define FPC_SLOW_FACTOR     4
// Timeouts in ms, by code
`define FPC_TMO_0           15'd0
`define FPC_TMO_1           15'd100
`define FPC_TMO_2           15'd250
`define FPC_TMO_3           15'd400
`define FPC_TMO_4           15'd667
`define FPC_TMO_5           15'd1000
`define FPC_TMO_6           15'd2000
`define FPC_TMO_7           15'd32000
// Time base: 35 s over 170 single steps gives a 206 ms slot
`define FPC_CLK_HZ          40000000
`define FPC_SLOT_MS         206
`define FPC_SLOT_CYCLES     ((`FPC_CLK_HZ / 1000) * `FPC_SLOT_MS)
`define FPC_MS_CYCLES       (`FPC_CLK_HZ / 1000)
`endif

// >>> core/fpc_pkg.sv
// Types and small decode functions for the fan drive setup block.
// Assumes fpc_consts.svh is on the include path.
`include "fpc_consts.svh"
package fpc_pkg;
   typedef logic [7:0]  fpc_byte_t;
   typedef logic [14:0] fpc_ms_t;

   // Ramp increment for a three-bit rate code
   function automatic fpc_byte_t fpc_step_of(input logic [2:0] code);
      fpc_byte_t s;
      s = `FPC_STEP_0;
      case (code)
         3'h1: s = `FPC_STEP_1;
         3'h2: s = `FPC_STEP_2;
         3'h3: s = `FPC_STEP_3;
         3'h4: s = `FPC_STEP_4;
         3'h5: s = `FPC_STEP_5;
         3'h6: s = `FPC_STEP_6;
         3'h7: s = `FPC_STEP_7;
         default: s = `FPC_STEP_0;
      endcase
      return s;
   endfunction

   // Timeout in ms for a three-bit timeout code
   function automatic fpc_ms_t fpc_tmo_of(input logic [2:0] code);
      fpc_ms_t t;
      t = `FPC_TMO_0;
      case (code)
         3'h1: t = `FPC_TMO_1;
         3'h2: t = `FPC_TMO_2;
         3'h3: t = `FPC_TMO_3;
         3'h4: t = `FPC_TMO_4;
         3'h5: t = `FPC_TMO_5;
         3'h6: t = `FPC_TMO_6;
         3'h7: t = `FPC_TMO_7;
         default: t = `FPC_TMO_0;
      endcase
      return t;
   endfunction
endpackage

// >>> core/fpc_ramp.sv
// One PWM channel: duty slewing toward a target and the polarity stage.
// Assumes the top supplies a shared free-running 8-bit PWM counter.
`timescale 1ns/1ps
`include "fpc_consts.svh"
module fpc_ramp #(
   parameter int SLOT_CYCLES = `FPC_SLOT_CYCLES
) (
   input  wire logic              i_sys_clk,
   input  wire logic              i_srst,
   input  wire logic              i_ramp_on,
   input  wire logic [2:0]        i_rate_code,
   input  wire logic              i_slow,
   input  wire logic              i_pol_high,
   input  wire fpc_pkg::fpc_byte_t i_target,
   input  wire fpc_pkg::fpc_byte_t i_pwm_cnt,
   output fpc_pkg::fpc_byte_t     o_duty,
   output logic                   o_pwm
);
   import fpc_pkg::*;

   logic [31:0] slot_cnt;
   logic [31:0] next_slot_cnt;
   logic [1:0]  slow_cnt;
   logic [1:0]  next_slow_cnt;
   fpc_byte_t   next_duty;
   logic        next_pwm;
   logic        slot_tick;
   fpc_byte_t   step;
   logic [8:0]  gap;

   // Slot timer; with the slow option only every fourth slot moves the duty
   always_comb
   begin
      step = fpc_step_of(i_rate_code);
      slot_tick = 1'b0;
      next_slot_cnt = slot_cnt + 32'h1;
      next_slow_cnt = slow_cnt;
      if (slot_cnt >= 32'(SLOT_CYCLES - 1))
      begin
         next_slot_cnt = 32'h0;
         next_slow_cnt = slow_cnt + 2'h1;
         slot_tick = !i_slow || (slow_cnt == 2'(`FPC_SLOW_FACTOR - 1));
      end
      // Step toward target, never overshoot; jump straight when ramping is off
      next_duty = o_duty;
      gap = 9'h0;
      if (!i_ramp_on)
         next_duty = i_target;
      else if (slot_tick)
      begin
         if (i_target > o_duty)
         begin
            gap = {1'b0, i_target} - {1'b0, o_duty};
            next_duty = (gap > {1'b0, step}) ? o_duty + step : i_target;
         end
         else if (i_target < o_duty)
         begin
            gap = {1'b0, o_duty} - {1'b0, i_target};
            next_duty = (gap > {1'b0, step}) ? o_duty - step : i_target;
         end
      end
      // Inverted polarity makes the drive active low
      next_pwm = (i_pwm_cnt < next_duty) ~^ i_pol_high;
   end

   // Registers of the channel
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         slot_cnt <= 32'h0;
         slow_cnt <= 2'h0;
         o_duty   <= 8'h00;
         o_pwm    <= 1'b0;
      end
      else
      begin
         slot_cnt <= next_slot_cnt;
         slow_cnt <= next_slow_cnt;
         o_duty   <= next_duty;
         o_pwm    <= next_pwm;
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);

   chk_ramp_step_bound: assert property (
      i_ramp_on && $past(i_ramp_on) |->
         (o_duty - $past(o_duty) <= step) || ($past(o_duty) - o_duty <= step))
      else $error("ramp moved by more than one step");
   chk_ramp_off_follow: assert property (!i_ramp_on |=> o_duty == $past(i_target))
      else $error("duty did not follow target with ramping off");
endmodule

// >>> core/fpc_top.sv
// Fan drive setup registers, four PWM channels with duty ramping on channels 3 and 4 only, and
// the self-clearing freewheel test for eight fans.
// Assumes a register master on the same clock and a fan loop feeding targets.
// Register lock and software reset arrive as plain same-clock inputs.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "fpc_consts.svh"
module fpc_top #(
   parameter int SLOT_CYCLES = `FPC_SLOT_CYCLES,
   parameter int MS_CYCLES   = `FPC_MS_CYCLES
) (
   input  wire logic               i_sys_clk,
   input  wire logic               i_srst,
   input  wire logic               i_sw_reset,
   input  wire logic               i_reg_lock,
   input  wire fpc_pkg::fpc_byte_t i_addr,
   input  wire fpc_pkg::fpc_byte_t i_wdata,
   input  wire logic               i_wr,
   input  wire logic               i_rd,
   output fpc_pkg::fpc_byte_t      o_rdata,
   input  wire fpc_pkg::fpc_byte_t i_target_ch1,
   input  wire fpc_pkg::fpc_byte_t i_target_ch2,
   input  wire fpc_pkg::fpc_byte_t i_target_ch3,
   input  wire fpc_pkg::fpc_byte_t i_target_ch4,
   output logic [3:0]              o_pwm,
   output logic [11:0]             o_ctrl_src,
   output logic [11:0]             o_spinup_tmo,
   output fpc_pkg::fpc_byte_t      o_fw_active
);
   import fpc_pkg::*;

   fpc_byte_t  ramp34;
   fpc_byte_t  fw_start;
   fpc_byte_t  fitted;
   fpc_byte_t  permit;
   fpc_byte_t  setup [4];
   fpc_byte_t  next_ramp34;
   fpc_byte_t  next_fw_start;
   fpc_byte_t  next_fitted;
   fpc_byte_t  next_permit;
   fpc_byte_t  next_setup [4];
   fpc_byte_t  next_rdata;
   fpc_byte_t  pwm_cnt;
   logic [15:0] ms_cnt;
   logic [15:0] next_ms_cnt;
   logic       ms_tick;
   fpc_ms_t    ms_left [8];
   fpc_ms_t    next_ms_left [8];
   logic [7:0] fw_done;
   logic [7:0] fw_launch;
   logic       wr_ok;
   fpc_byte_t  target [4];
   logic [3:0] ramp_on;
   logic [3:0] pwm_raw;
   fpc_byte_t  setup_rst [4];

   assign setup_rst[0] = `FPC_RST_CH1_SETUP;
   assign setup_rst[1] = `FPC_RST_CH2_SETUP;
   assign setup_rst[2] = `FPC_RST_CH3_SETUP;
   assign setup_rst[3] = `FPC_RST_CH4_SETUP;

   // Writes are dropped while the lock is held
   assign wr_ok = i_wr && !i_reg_lock;

   // Register file and read path
   always_comb
   begin
      next_ramp34 = ramp34;
      next_fitted = fitted;
      next_permit = permit;
      for (int c = 0; c < 4; c++)
         next_setup[c] = setup[c];
      // Start bits for a fan not both fitted and permitted are dropped at the
      // write, so no test ever starts only to be aborted a cycle later
      fw_launch = 8'h00;
      if (wr_ok)
      begin
         case (i_addr)
            `FPC_OFS_RAMP34:    next_ramp34 = i_wdata;
            `FPC_OFS_FITTED:    next_fitted = i_wdata;
            `FPC_OFS_FW_PERMIT: next_permit = i_wdata;
            `FPC_OFS_FW_START:  fw_launch = i_wdata & fitted & permit;
            `FPC_OFS_CH1_SETUP: next_setup[0] = i_wdata;
            `FPC_OFS_CH2_SETUP: next_setup[1] = i_wdata;
            `FPC_OFS_CH3_SETUP: next_setup[2] = i_wdata;
            `FPC_OFS_CH4_SETUP: next_setup[3] = i_wdata;
            default: next_ramp34 = ramp34;
         endcase
      end
      // A new start in the cycle of expiry wins and restarts the test
      next_fw_start = (fw_start & ~fw_done) | fw_launch;
      next_rdata = `FPC_RST_ZERO;
      if (i_rd)
      begin
         case (i_addr)
            `FPC_OFS_RAMP34:    next_rdata = ramp34;
            `FPC_OFS_FW_START:  next_rdata = fw_start;
            `FPC_OFS_FITTED:    next_rdata = fitted;
            `FPC_OFS_FW_PERMIT: next_rdata = permit;
            `FPC_OFS_CH1_SETUP: next_rdata = setup[0];
            `FPC_OFS_CH2_SETUP: next_rdata = setup[1];
            `FPC_OFS_CH3_SETUP: next_rdata = setup[2];
            `FPC_OFS_CH4_SETUP: next_rdata = setup[3];
            default:            next_rdata = `FPC_RST_ZERO;
         endcase
      end
   end

   // Power-on and software reset both restore every register
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst || i_sw_reset)
      begin
         ramp34   <= `FPC_RST_ZERO;
         fw_start <= `FPC_RST_ZERO;
         fitted   <= `FPC_RST_ZERO;
         permit   <= `FPC_RST_ZERO;
         for (int c = 0; c < 4; c++)
            setup[c] <= setup_rst[c];
         o_rdata  <= `FPC_RST_ZERO;
      end
      else
      begin
         ramp34   <= next_ramp34;
         fw_start <= next_fw_start;
         fitted   <= next_fitted;
         permit   <= next_permit;
         for (int c = 0; c < 4; c++)
            setup[c] <= next_setup[c];
         o_rdata  <= next_rdata;
      end
   end

   // Millisecond time base shared by all fan tests
   // One shared divider keeps eight timers cheap; the cost is that a test may
   // end up to one millisecond early, since the first tick after a start can
   // come anywhere within the first millisecond
   always_comb
   begin
      ms_tick = (ms_cnt >= 16'(MS_CYCLES - 1));
      next_ms_cnt = ms_tick ? 16'h0 : ms_cnt + 16'h1;
   end

   // Per-fan timeout counters; fans pair onto channels two at a time
   for (genvar f = 0; f < 8; f++)
   begin : g_fan
      always_comb
      begin
         fw_done[f] = fw_start[f] && (ms_left[f] == `FPC_TMO_0);
         next_ms_left[f] = ms_left[f];
         if (fw_launch[f])
            next_ms_left[f] = fpc_tmo_of(setup[f / 2][`FPC_TMO_LSB +: 3]);
         else if (fw_start[f] && ms_tick && ms_left[f] != `FPC_TMO_0)
            next_ms_left[f] = ms_left[f] - 15'h1;
      end
   end

   // Time base, counters and registered outputs
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst || i_sw_reset)
      begin
         ms_cnt <= 16'h0;
         pwm_cnt <= 8'h00;
         for (int f = 0; f < 8; f++)
            ms_left[f] <= `FPC_TMO_0;
         o_ctrl_src <= 12'h000;
         o_spinup_tmo <= 12'h000;
         o_fw_active <= `FPC_RST_ZERO;
         o_pwm <= 4'h0;
      end
      else
      begin
         ms_cnt <= next_ms_cnt;
         pwm_cnt <= pwm_cnt + 8'h01;
         for (int f = 0; f < 8; f++)
            ms_left[f] <= next_ms_left[f];
         for (int c = 0; c < 4; c++)
         begin
            o_ctrl_src[c*3 +: 3] <= setup[c][`FPC_SRC_LSB +: 3];
            o_spinup_tmo[c*3 +: 3] <= setup[c][`FPC_TMO_LSB +: 3];
         end
         o_fw_active <= fw_start;
         o_pwm <= pwm_raw;
      end
   end

   // Channels 1 and 2 have no ramp control here and follow their target,
   // because their ramp register lives outside this block
   assign ramp_on = {ramp34[`FPC_BIT_EN4], ramp34[`FPC_BIT_EN3], 2'b00};
   assign target[0] = i_target_ch1;
   assign target[1] = i_target_ch2;
   assign target[2] = i_target_ch3;
   assign target[3] = i_target_ch4;

   // One duty/polarity stage per channel
   // Channels 1 and 2 still get a stage so polarity and source off work there
   for (genvar c = 0; c < 4; c++)
   begin : g_ch
      logic [2:0] rate;
      fpc_byte_t  eff_target;
      assign rate = (c == 3) ? ramp34[`FPC_RATE4_LSB +: 3] : ramp34[`FPC_RATE3_LSB +: 3];
      // Source off drives the fan to zero duty
      assign eff_target = (setup[c][`FPC_SRC_LSB +: 3] == `FPC_SRC_OFF) ? 8'h00 : target[c];
      fpc_ramp #(
         .SLOT_CYCLES(SLOT_CYCLES)
      ) u_ramp (
         .i_sys_clk  (i_sys_clk),
         .i_srst     (i_srst),
         .i_ramp_on  (ramp_on[c]),
         .i_rate_code(rate),
         .i_slow     (setup[c][`FPC_BIT_SLOW]),
         .i_pol_high (setup[c][`FPC_BIT_POL]),
         .i_target   (eff_target),
         .i_pwm_cnt  (pwm_cnt),
         .o_duty     (),
         .o_pwm      (pwm_raw[c])
      );
   end

   // Checks run on the system clock; power-on reset silences them, and software
   // reset, which rewrites every register, is excluded in each antecedent except the permit, fitted, read-idle and reset-value checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);

   chk_start_needs_permit: assert property (
      $rose(fw_start[0]) |-> $past(permit[0]))
      else $error("fan 1 test started without permit");
   chk_start_needs_fitted: assert property (
      fw_start != 8'h00 && $past(fw_start) == 8'h00 |-> ($past(fitted) & fw_start) == fw_start)
      else $error("test started on a fan not fitted");
   chk_start_self_clear: assert property (
      fw_done[0] && !fw_launch[0] && !i_sw_reset |=> !fw_start[0])
      else $error("test bit did not clear itself");
   chk_zero_tmo_ends: assert property (
      fw_launch[6] && setup[3][2:0] == 3'h0 && !i_sw_reset |=> fw_done[6])
      else $error("zero timeout test did not end at once");
   chk_lock_blocks_write: assert property (
      i_wr && i_reg_lock && !i_sw_reset |=>
         $stable(setup[0]) && $stable(setup[2]) && $stable(ramp34) && $stable(fitted))
      else $error("locked register was written");
   chk_sw_reset_values: assert property (
      i_sw_reset |=> setup[0] == 8'h11 && setup[3] == 8'h71 && ramp34 == 8'h00)
      else $error("software reset missed reset values");
   chk_read_unmapped: assert property (
      i_rd && i_addr == 8'h20 && !i_sw_reset |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_src_mirror: assert property (
      !i_sw_reset && !$past(i_sw_reset) |=> o_ctrl_src[2:0] == $past(setup[0][7:5]))
      else $error("control source output wrong");

   // Register port: read data stand one cycle, then the port idles at zero
   chk_rdata_one_cycle: assert property (
      !i_rd |=> o_rdata == `FPC_RST_ZERO)
      else $error("read data stood longer than one cycle");
   chk_read_returns: assert property (
      i_rd && i_addr == `FPC_OFS_FITTED && !i_sw_reset |=> o_rdata == $past(fitted))
      else $error("fitted map read wrong");
   chk_ramp_write_lands: assert property (
      wr_ok && i_addr == `FPC_OFS_RAMP34 && !i_sw_reset |=> ramp34 == $past(i_wdata))
      else $error("ramp register write lost");
   chk_permit_write_lands: assert property (
      wr_ok && i_addr == `FPC_OFS_FW_PERMIT && !i_sw_reset |=> permit == $past(i_wdata))
      else $error("permit register write lost");

   // Freewheel: refused starts never set a bit, and timers only count down
   chk_start_refused: assert property (
      i_wr && i_addr == `FPC_OFS_FW_START && !i_sw_reset |=>
         ((fw_start & ~$past(fw_start)) & ~($past(fitted) & $past(permit))) == 8'h00)
      else $error("test started on a refused fan");
   chk_tmo_count_down: assert property (
      fw_start[0] && !fw_launch[0] && !i_sw_reset |=> ms_left[0] <= $past(ms_left[0]))
      else $error("test timer moved upward");
   chk_fw_active_copy: assert property (
      !i_sw_reset |=> o_fw_active == $past(fw_start))
      else $error("test active output wrong");

   // Registered outputs follow their sources one cycle later
   chk_tmo_mirror: assert property (
      !i_sw_reset |=> o_spinup_tmo[11:9] == $past(setup[3][2:0]))
      else $error("timeout output wrong");
   chk_src_mirror_ch4: assert property (
      !i_sw_reset |=> o_ctrl_src[11:9] == $past(setup[3][7:5]))
      else $error("channel 4 source output wrong");
   chk_pwm_pipeline: assert property (
      !i_sw_reset |=> o_pwm == $past(pwm_raw))
      else $error("pwm output wrong");

   cov_test_done: cover property (fw_start[0] ##1 !fw_start[0]);
   cov_ramp_ch3: cover property (ramp34[0] && setup[2][3]);
   cov_locked_write: cover property (i_wr && i_reg_lock);
   cov_zero_tmo: cover property (fw_launch[6] && setup[3][2:0] == 3'h0);
endmodule

// >>> tb/fpc_fan_model.sv
// Model of the four fans on the PWM outputs: each fan senses its drive duty.
// Assumes the bench tells each fan which output level means drive on.
`timescale 1ns/1ps
module fpc_fan_model (
   input  wire logic       i_sys_clk,
   input  wire logic [3:0] i_pwm,
   input  wire logic [3:0] i_pol_high,
   output int              o_meas [4]
);
   int         acc [4];
   logic [7:0] win = 8'h00;

   // Count driven cycles over each 256-cycle window, matching the PWM period.
   // The result lags by up to two windows, so callers must let it settle.
   always @(posedge i_sys_clk)
   begin
      win <= win + 8'h01;
      for (int c = 0; c < 4; c++)
      begin
         if (win == 8'hFF)
         begin
            o_meas[c] <= acc[c] + ((i_pwm[c] === i_pol_high[c]) ? 1 : 0);
            acc[c]    <= 0;
         end
         else
         begin
            acc[c] <= acc[c] + ((i_pwm[c] === i_pol_high[c]) ? 1 : 0);
         end
      end
   end
endmodule

// >>> tb/fpc_top_tb_top.sv
// Self-checking bench for the fan drive setup and freewheel test block.
// Assumes shortened slot and millisecond counts so the run stays short.
`timescale 1ns/1ps
module fpc_top_tb_top;
   import fpc_pkg::*;
   localparam int SLOT = 20;
   localparam int MSC  = 8;
   logic        sys_clk;
   logic        srst;
   logic        sw_reset;
   logic        reg_lock;
   logic        wr;
   logic        rd;
   fpc_byte_t   addr;
   fpc_byte_t   wdata;
   fpc_byte_t   rdata;
   fpc_byte_t   tgt [4];
   logic [3:0]  pwm;
   logic [3:0]  pol;
   logic [11:0] ctrl_src;
   logic [11:0] spinup_tmo;
   fpc_byte_t   fw_active;
   int          meas [4];
   int          failures;
   int          checks;
   int          seed;
   int          mdl [int];
   int          steps [8] = '{1, 2, 3, 5, 8, 12, 24, 48};
   int          tmo_ms [8] = '{0, 100, 250, 400, 667, 1000, 2000, 32000};
   int          ofs [8] = '{8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h21, 8'h22, 8'h23, 8'h24};

   fpc_top #(.SLOT_CYCLES(SLOT), .MS_CYCLES(MSC)) u_fpc_top (
      .i_sys_clk(sys_clk), .i_srst(srst), .i_sw_reset(sw_reset), .i_reg_lock(reg_lock),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_target_ch1(tgt[0]), .i_target_ch2(tgt[1]), .i_target_ch3(tgt[2]),
      .i_target_ch4(tgt[3]), .o_pwm(pwm), .o_ctrl_src(ctrl_src),
      .o_spinup_tmo(spinup_tmo), .o_fw_active(fw_active));

   fpc_fan_model u_fpc_fan_model (.i_sys_clk(sys_clk), .i_pwm(pwm), .i_pol_high(pol),
      .o_meas(meas));

   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Power-on values of the register model
   function automatic void mdl_reset();
      foreach (ofs[i]) mdl[ofs[i]] = 0;
      mdl[8'h21] = 8'h11;
      mdl[8'h22] = 8'h31;
      mdl[8'h23] = 8'h51;
      mdl[8'h24] = 8'h71;
   endfunction

   // Expected packed field of all four setup registers at bit offset sh
   function automatic logic [11:0] exp_fld(input int sh);
      logic [11:0] e;
      e = 12'h000;
      for (int c = 0; c < 4; c++) e |= 12'((mdl[8'h21 + c] >> sh) & 7) << (3 * c);
      return e;
   endfunction

   // Start bits self-clear, so the model leaves that register alone
   task automatic wr_reg(input int a, input int d);
      @(posedge sys_clk);
      wr    <= 1'b1;
      addr  <= a[7:0];
      wdata <= d[7:0];
      @(posedge sys_clk);
      wr <= 1'b0;
      if (!reg_lock && mdl.exists(a) && a != 8'h1C) mdl[a] = d & 8'hFF;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input int a);
      @(posedge sys_clk);
      rd   <= 1'b1;
      addr <= a[7:0];
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      chk(rdata, mdl.exists(a) ? mdl[a] : 0);
   endtask

   // Launch a fan test and time how long it stays active
   task automatic fw_run(input int f);
      int ok;
      int t;
      int n;
      int hi;
      ok = (mdl[8'h1D] >> f) & (mdl[8'h1E] >> f) & 1;
      t  = tmo_ms[mdl[8'h21 + f / 2] & 7] * MSC;
      n  = 0;
      hi = 0;
      wr_reg(8'h1C, 1 << f);
      repeat (ok ? t + MSC + 16 : 16)
      begin
         @(posedge sys_clk);
         #1;
         if (fw_active[f] === 1'b1) hi = 1;
         else if (hi) break;
         n++;
      end
      chk(hi, ok);
      // The first tick after a start comes within a millisecond, so a test
      // may end up to one millisecond early but never late
      if (ok) chk(n > t - MSC && n <= t + 2, 1);
   endtask

   // Drive one channel to zero, then ramp it up with the given code
   task automatic ramp_run(input int ch, input int code, input int slow, input int pl);
      int x;
      int sh;
      int en;
      int full;
      x  = 96 + ($random(seed) & 15);
      sh = (ch == 2) ? 2 : 5;
      en = (ch == 2) ? 1 : 2;
      wr_reg(8'h21 + ch, (mdl[8'h21 + ch] & 8'hE7) | (slow << 3) | (pl << 4));
      wr_reg(8'h1B, mdl[8'h1B] & ~en);
      tgt[ch] <= 8'h00;
      pol[ch] = pl[0];
      repeat (600) @(posedge sys_clk);
      chk(meas[ch], 0);
      wr_reg(8'h1B, (mdl[8'h1B] & ~(en | (7 << sh))) | en | (code << sh));
      tgt[ch] <= x[7:0];
      full = ((x + steps[code] - 1) / steps[code] + 1) * SLOT * (slow ? 4 : 1);
      repeat (full / 2) @(posedge sys_clk);
      chk(meas[ch] < x, 1);
      repeat (full / 2 + 600) @(posedge sys_clk);
      chk(meas[ch], x);
   endtask

   // Hang guard, sized well above the expected run length
   initial
   begin
      repeat (80000) @(posedge sys_clk);
      failures++;
      tally_and_finish();
   end

   initial
   begin
      seed = 39223;
      failures = 0;
      checks = 0;
      {srst, sw_reset, reg_lock, wr, rd} = 5'b10000;
      addr = 8'h00;
      wdata = 8'h00;
      pol = 4'hF;
      foreach (tgt[i]) tgt[i] = 8'h00;
      mdl_reset();
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      foreach (ofs[i]) rd_chk(ofs[i]);
      rd_chk(8'h20);
      chk(ctrl_src, exp_fld(5));
      chk(spinup_tmo, exp_fld(0));
      $display("test reset values done");

      for (int i = 0; i < 6; i++) wr_reg(ofs[i < 2 ? 0 : i], $random(seed));
      wr_reg(8'h20, 8'h5A);
      foreach (ofs[i]) rd_chk(ofs[i]);
      rd_chk(8'h20);
      reg_lock <= 1'b1;
      wr_reg(8'h23, 8'hFF);
      wr_reg(8'h1D, 8'hA5);
      reg_lock <= 1'b0;
      rd_chk(8'h23);
      rd_chk(8'h1D);
      @(posedge sys_clk);
      sw_reset <= 1'b1;
      @(posedge sys_clk);
      sw_reset <= 1'b0;
      mdl_reset();
      foreach (ofs[i]) rd_chk(ofs[i]);
      $display("test access and lock done");

      tgt[0] <= 8'h40 | 8'($random(seed));
      tgt[1] <= 8'($random(seed));
      for (int k = 0; k < 8; k++)
      begin
         wr_reg(8'h21, (k * 8'h21) | 8'h10);
         repeat (600) @(posedge sys_clk);
         chk(ctrl_src, exp_fld(5));
         chk(spinup_tmo, exp_fld(0));
         chk(meas[0], (k == 4) ? 0 : tgt[0]);
         chk(meas[1], tgt[1]);
      end
      $display("test source and timeout codes done");

      wr_reg(8'h21, 8'h11);
      wr_reg(8'h22, 8'h32);
      wr_reg(8'h23, 8'h53);
      wr_reg(8'h24, 8'h70);
      // Fan 4 lacks its permit, fan 5 is not fitted, fans 6 and 7 have no timeout
      wr_reg(8'h1D, 8'hDF);
      wr_reg(8'h1E, 8'hEF);
      for (int f = 0; f < 8; f++) fw_run(f);
      rd_chk(8'h1C);
      $display("test freewheel done");

      ramp_run(2, 0, 0, 1);
      ramp_run(2, 6, 1, 0);
      for (int k = 0; k < 8; k++) ramp_run(3, k, k & 1, (k >> 1) & 1);
      $display("test ramping done");
      tally_and_finish();
   end
endmodule
